// >>> inc/lcd_seg_defines.svh
// register indices, field positions, reset values and timing counts
`ifndef LCD_SEG_DEFINES_SVH
`define LCD_SEG_DEFINES_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LCD_IDX_RAM_BASE    16'hF740
`define LCD_IDX_RAM_LAST    16'hF74F
`define LCD_IDX_PIN_DUTY    16'hFFC0
`define LCD_IDX_DISP_CTRL   16'hFFC1
`define LCD_IDX_DISP_CTRL2  16'hFFC2
`define LCD_IDX_CLK_GATE2   16'hFFFB
`define LCD_ADDR_W          18

// ----------------------------------------------------------------
// pin and duty control fields
// ----------------------------------------------------------------
`define LCD_PD_DUTY_HI      7
`define LCD_PD_DUTY_LO      6
`define LCD_PD_DOUBLING     5
`define LCD_PD_RSVD         4
`define LCD_PD_RESET        8'h00

// ----------------------------------------------------------------
// display control fields
// ----------------------------------------------------------------
`define LCD_DC_FIXED_ONE    7
`define LCD_DC_POWER_SW     6
`define LCD_DC_ACTIVE       5
`define LCD_DC_DISPLAY      4
`define LCD_DC_RESET        8'h80

// ----------------------------------------------------------------
// second display control and clock gate fields
// ----------------------------------------------------------------
`define LCD_DC2_WAVE_B      7
`define LCD_DC2_LADDER_CUT  6
`define LCD_DC2_RESET       8'h00
`define LCD_CG_LCD_RUN      0
`define LCD_CG_RESET        8'hFF

// ----------------------------------------------------------------
// frame timing
// ----------------------------------------------------------------
`define LCD_FRAME_SEL_COUNT 4'hB
`define LCD_FRAME_BASE_SHIFT 5'h08
`define LCD_DIV_W           20

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define LCD_RESP_OKAY       2'h0
`define LCD_RESP_SLVERR     2'h2

`endif

// >>> inc/lcd_seg_pkg.sv
// types shared by the segment display controller
package lcd_seg_pkg;

	typedef enum logic [1:0] {
		DUTY_STATIC  = 2'b00,
		DUTY_HALF    = 2'b01,
		DUTY_THIRD   = 2'b10,
		DUTY_QUARTER = 2'b11
	} duty_type;

	typedef enum logic {
		WAVE_A = 1'b0,
		WAVE_B = 1'b1
	} wave_type;

endpackage

// >>> rtl/lcd_common_map.sv
// slot sequencing, drive polarity and common pin mapping
`timescale 1ns/1ns
`include "lcd_seg_defines.svh"
module lcd_common_map (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	// control
	input  wire logic                 run,
	input  wire logic                 slotTick,
	input  wire lcd_seg_pkg::duty_type duty,
	input  wire logic                 doubling,
	input  wire lcd_seg_pkg::wave_type waveSel,
	// state
	output logic [1:0]                slot,
	output logic                      polarity,
	output logic [3:0]                comLevel
);

	logic [1:0] lastSlot;
	logic [3:0] slotHot;
	logic [3:0] comSel;

	assign lastSlot = duty;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			slot     <= 2'h0;
			polarity <= 1'b0;
		end else if (!run) begin
			slot     <= 2'h0;
			polarity <= 1'b0;
		end else if (slotTick) begin
			slot <= (slot >= lastSlot) ? 2'h0 : slot + 2'h1;
			// type A inverts every slot, type B once per frame
			if (waveSel == lcd_seg_pkg::WAVE_A || slot >= lastSlot) begin
				polarity <= ~polarity;
			end
		end
	end

	always_comb begin
		slotHot = 4'h1 << slot;
		comSel  = 4'h0;
		case (duty)
			lcd_seg_pkg::DUTY_STATIC: begin
				comSel = doubling ? {4{slotHot[0]}} : {3'h0, slotHot[0]};
			end
			lcd_seg_pkg::DUTY_HALF: begin
				if (doubling) begin
					comSel = {{2{slotHot[1]}}, {2{slotHot[0]}}};
				end else begin
					comSel = {2'h0, slotHot[1:0]};
				end
			end
			lcd_seg_pkg::DUTY_THIRD: begin
				comSel = {1'b0, slotHot[2:0]};
			end
			lcd_seg_pkg::DUTY_QUARTER: begin
				comSel = slotHot;
			end
			default: begin
				comSel = 4'h0;
			end
		endcase
	end

	// selected common swings opposite to polarity, others follow it
	always_comb begin
		comLevel = {4{polarity}} ^ comSel;
	end

endmodule

// >>> rtl/lcd_frame_timer.sv
// slot tick generator for the eleven selectable frame rates
`timescale 1ns/1ns
`include "lcd_seg_defines.svh"
module lcd_frame_timer (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	// control
	input  wire logic       run,
	input  wire logic [3:0] frameSel,
	// timing
	output logic            slotTick
);

	logic [`LCD_DIV_W-1:0] divCount_r;
	logic [3:0]            selClamp;
	logic [4:0]            shiftAmt;
	logic [`LCD_DIV_W-1:0] divMask;

	// codes past the last rate alias to the slowest one
	always_comb begin
		selClamp = (frameSel < `LCD_FRAME_SEL_COUNT) ? frameSel : (`LCD_FRAME_SEL_COUNT - 4'h1);
		shiftAmt = `LCD_FRAME_BASE_SHIFT + {1'b0, selClamp};
		divMask  = `LCD_DIV_W'((`LCD_DIV_W+1)'(1) << shiftAmt) - `LCD_DIV_W'(1);
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			divCount_r <= '0;
		end else if (!run) begin
			divCount_r <= '0;
		end else begin
			divCount_r <= divCount_r + `LCD_DIV_W'(1);
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			slotTick <= 1'b0;
		end else begin
			slotTick <= run && ((divCount_r & divMask) == divMask);
		end
	end

endmodule

// >>> rtl/lcd_segment_driver_ctrl.sv
// segment display controller with its register file and display memory
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ns
`include "lcd_seg_defines.svh"
module lcd_segment_driver_ctrl (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// axi4-lite write address
	input  wire logic [17:0] awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	// axi4-lite write data
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// axi4-lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read address
	input  wire logic [17:0] araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	// axi4-lite read data
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// chip power state
	input  wire logic        standbyMode,
	// general port data for pins not used as segments
	input  wire logic [31:0] portData,
	// panel drive
	output logic [31:0]      segmentOutputs,
	output logic [31:0]      segmentIsPort,
	output logic             commonOut1,
	output logic             commonOut2,
	output logic             commonOut3,
	output logic             commonOut4,
	output logic [3:0]       commonUsed,
	// drive supply control
	output logic             drivePowerOn,
	output logic             ladderConnected
);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] regIndex(input logic [17:0] addr);
		regIndex = addr[17:2];
	endfunction

	function automatic logic isRam(input logic [15:0] idx);
		isRam = (idx >= `LCD_IDX_RAM_BASE) && (idx <= `LCD_IDX_RAM_LAST);
	endfunction

	function automatic logic isMapped(input logic [15:0] idx);
		isMapped = isRam(idx) || idx == `LCD_IDX_PIN_DUTY || idx == `LCD_IDX_DISP_CTRL
			|| idx == `LCD_IDX_DISP_CTRL2 || idx == `LCD_IDX_CLK_GATE2;
	endfunction

	// group g (pins 4g+1..4g+4) is a segment driver for this select code
	function automatic logic groupIsSeg(input logic [3:0] sel, input logic [2:0] g);
		if (sel[3]) begin
			groupIsSeg = g >= sel[2:0];
		end else begin
			groupIsSeg = {1'b0, g} < sel;
		end
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0]  pinDuty_r;
	logic [6:0]  dispCtrl_r;
	logic [7:0]  dispCtrl2_r;
	logic [7:0]  clkGate2_r;
	logic [7:0]  ram_r [16];

	logic [15:0] wrIdx;
	logic [15:0] rdIdx;
	logic        wrFire;
	logic        rdFire;
	logic [3:0]  wrRamSel;
	logic [3:0]  rdRamSel;
	logic [31:0] rdWord;

	logic                  run;
	logic                  slotTick;
	logic [1:0]            slot;
	logic                  polarity;
	logic [3:0]            comLevel;
	lcd_seg_pkg::duty_type duty;
	lcd_seg_pkg::wave_type waveSel;
	logic [31:0]           segWave;
	logic [31:0]           portMask;
	logic [3:0]            usedMask;

	assign wrIdx    = regIndex(awaddr);
	assign rdIdx    = regIndex(araddr);
	assign wrRamSel = wrIdx[3:0];
	assign rdRamSel = rdIdx[3:0];

	// both channels are taken together, once the previous response has gone
	assign wrFire = awvalid && wvalid && !awready && !bvalid;
	assign rdFire = arvalid && !arready && !rvalid;

	// ----------------------------------------------------------------
	// write channel handshake
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			awready <= 1'b0;
			wready  <= 1'b0;
		end else begin
			awready <= wrFire;
			wready  <= wrFire;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			bvalid <= 1'b0;
			bresp  <= `LCD_RESP_OKAY;
		end else if (awready) begin
			bvalid <= 1'b1;
			bresp  <= isMapped(wrIdx) ? `LCD_RESP_OKAY : `LCD_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// control register writes
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pinDuty_r <= `LCD_PD_RESET;
		end else if (wrFire && wstrb[0] && wrIdx == `LCD_IDX_PIN_DUTY) begin
			pinDuty_r <= wdata[7:0];
			// reserved position holds nothing, whatever software sends
			pinDuty_r[`LCD_PD_RSVD] <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dispCtrl_r <= 7'(`LCD_DC_RESET);
		end else if (wrFire && wstrb[0] && wrIdx == `LCD_IDX_DISP_CTRL) begin
			dispCtrl_r <= wdata[6:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dispCtrl2_r <= `LCD_DC2_RESET;
		end else if (wrFire && wstrb[0] && wrIdx == `LCD_IDX_DISP_CTRL2) begin
			dispCtrl2_r <= wdata[7:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			clkGate2_r <= `LCD_CG_RESET;
		end else if (wrFire && wstrb[0] && wrIdx == `LCD_IDX_CLK_GATE2) begin
			clkGate2_r <= wdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// display memory
	// ----------------------------------------------------------------
	// memory content is undefined after reset, so it is not cleared
	always_ff @(posedge clk_sys) begin
		if (wrFire && isRam(wrIdx)) begin
			if (wstrb[0]) begin
				ram_r[wrRamSel] <= wdata[7:0];
			end
			// word access: an even location also takes its odd partner
			if (wstrb[1] && !wrRamSel[0]) begin
				ram_r[wrRamSel | 4'h1] <= wdata[15:8];
			end
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	always_comb begin
		rdWord = 32'h0000_0000;
		if (isRam(rdIdx)) begin
			rdWord[7:0] = ram_r[rdRamSel];
			if (!rdRamSel[0]) begin
				rdWord[15:8] = ram_r[rdRamSel | 4'h1];
			end
		end else if (rdIdx == `LCD_IDX_PIN_DUTY) begin
			rdWord[7:0] = pinDuty_r;
		end else if (rdIdx == `LCD_IDX_DISP_CTRL) begin
			rdWord[7:0] = {1'b1, dispCtrl_r};
		end else if (rdIdx == `LCD_IDX_DISP_CTRL2) begin
			rdWord[7:0] = dispCtrl2_r;
		end else if (rdIdx == `LCD_IDX_CLK_GATE2) begin
			rdWord[7:0] = clkGate2_r;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			arready <= 1'b0;
		end else begin
			arready <= rdFire;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `LCD_RESP_OKAY;
		end else if (rdFire) begin
			rvalid <= 1'b1;
			rdata  <= rdWord;
			rresp  <= isMapped(rdIdx) ? `LCD_RESP_OKAY : `LCD_RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// waveform timing
	// ----------------------------------------------------------------
	assign duty    = lcd_seg_pkg::duty_type'(pinDuty_r[`LCD_PD_DUTY_HI:`LCD_PD_DUTY_LO]);
	assign waveSel = lcd_seg_pkg::wave_type'(dispCtrl2_r[`LCD_DC2_WAVE_B]);

	// halted by chip standby, by its own clock gate bit or by a clear display active bit
	assign run = !standbyMode && clkGate2_r[`LCD_CG_LCD_RUN]
		&& dispCtrl_r[`LCD_DC_ACTIVE];

	lcd_frame_timer frameTimer (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.run      (run),
		.frameSel (dispCtrl_r[3:0]),
		.slotTick (slotTick)
	);

	lcd_common_map commonMap (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.run      (run),
		.slotTick (slotTick),
		.duty     (duty),
		.doubling (pinDuty_r[`LCD_PD_DOUBLING]),
		.waveSel  (waveSel),
		.slot     (slot),
		.polarity (polarity),
		.comLevel (comLevel)
	);

	// ----------------------------------------------------------------
	// segment data and pin function
	// ----------------------------------------------------------------
	// segment s sits in byte s/2, nibble s%2, bit per common slot
	always_comb begin
		for (int s = 0; s < 32; s++) begin
			segWave[s]  = polarity ^ ~(dispCtrl_r[`LCD_DC_DISPLAY]
				&& ram_r[s / 2][(s % 2) * 4 + int'(slot)]);
			portMask[s] = !groupIsSeg(pinDuty_r[3:0], 3'(s / 4));
		end
	end

	always_comb begin
		case (duty)
			lcd_seg_pkg::DUTY_STATIC: begin
				usedMask = pinDuty_r[`LCD_PD_DOUBLING] ? 4'hF : 4'h1;
			end
			lcd_seg_pkg::DUTY_HALF: begin
				usedMask = pinDuty_r[`LCD_PD_DOUBLING] ? 4'hF : 4'h3;
			end
			lcd_seg_pkg::DUTY_THIRD: begin
				usedMask = 4'h7;
			end
			default: begin
				usedMask = 4'hF;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// output stage
	// ----------------------------------------------------------------
	// stopped display parks every driven line low, so no dc sits on the glass
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			segmentOutputs <= 32'h0000_0000;
		end else begin
			for (int s = 0; s < 32; s++) begin
				if (portMask[s]) begin
					segmentOutputs[s] <= portData[s];
				end else begin
					segmentOutputs[s] <= run && segWave[s];
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			segmentIsPort <= 32'hFFFF_FFFF;
		end else begin
			segmentIsPort <= portMask;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			commonOut1 <= 1'b0;
			commonOut2 <= 1'b0;
			commonOut3 <= 1'b0;
			commonOut4 <= 1'b0;
			commonUsed <= 4'h0;
		end else begin
			commonOut1 <= run && comLevel[0] && usedMask[0];
			commonOut2 <= run && comLevel[1] && usedMask[1];
			commonOut3 <= run && comLevel[2] && usedMask[2];
			commonOut4 <= run && comLevel[3] && usedMask[3];
			commonUsed <= run ? usedMask : 4'h0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			drivePowerOn    <= 1'b0;
			ladderConnected <= 1'b1;
		end else begin
			drivePowerOn    <= run && dispCtrl_r[`LCD_DC_POWER_SW];
			ladderConnected <= !dispCtrl2_r[`LCD_DC2_LADDER_CUT];
		end
	end

endmodule

// >>> test/lcd_panel_model.sv
// passive panel stand-in counting level changes on each common electrode
`timescale 1ns/1ns
module lcd_panel_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	// bench control
	input  wire logic       clearCounts,
	// electrodes
	input  wire logic [3:0] commons,
	// observation
	output logic [3:0][7:0] changeCount
);
	logic [3:0] last_r;
	// a panel only loads its pins, so nothing is driven back
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			last_r <= 4'h0;
			changeCount <= '0;
		end else begin
			last_r <= commons;
			for (int i = 0; i < 4; i++)
				if (clearCounts) changeCount[i] <= 8'h00;
				else if (commons[i] != last_r[i]) changeCount[i] <= changeCount[i] + 8'h01;
		end
	end
endmodule

// >>> test/lcd_seg_ctrl_sva.sv
// bus handshake and panel drive assertions for the segment controller
`timescale 1ns/1ns
`include "lcd_seg_defines.svh"
module lcd_seg_ctrl_sva (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// register bus
	input  wire logic        awready,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	input  wire logic        bready,
	input  wire logic        arready,
	input  wire logic        rvalid,
	input  wire logic        rready,
	// panel drive
	input  wire logic        standbyMode,
	input  wire logic [31:0] portData,
	input  wire logic [31:0] segmentOutputs,
	input  wire logic [31:0] segmentIsPort,
	input  wire logic        commonOut1,
	input  wire logic        commonOut2,
	input  wire logic        commonOut3,
	input  wire logic        commonOut4,
	input  wire logic [3:0]  commonUsed,
	input  wire logic        drivePowerOn
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic [3:0] com;
	assign com = {commonOut4, commonOut3, commonOut2, commonOut1};
	// ----
	// register bus
	// ----
	aw_w_pair_a: assert property (awready == wready)
		else $error("write address and data accepted apart");
	write_pulse_a: assert property (awready |=> !awready)
		else $error("write accept longer than one cycle");
	write_resp_a: assert property (awready |=> bvalid)
		else $error("write response late");
	write_retire_a: assert property (bvalid && bready |=> !bvalid)
		else $error("write response not retired");
	read_answer_a: assert property (arready |-> rvalid)
		else $error("read data not with accept");
	read_retire_a: assert property (rvalid && rready |=> !rvalid)
		else $error("read data not retired");
	// ----
	// panel drive
	// ----
	standby_dark_a: assert property (standbyMode [*3] |-> com == 4'h0 && !drivePowerOn)
		else $error("display still driven in standby");
	unused_low_a: assert property (commonUsed == $past(commonUsed, 2) |-> (com & ~commonUsed) == 4'h0)
		else $error("unused common driven");
	used_set_a: assert property (commonUsed inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
		else $error("illegal common set");
	// registered output, so only judged once inputs have settled a cycle
	port_pins_a: assert property ($past(rstn) && $stable(portData)
		&& $stable(segmentIsPort)
		|-> ((segmentOutputs ^ portData) & segmentIsPort) == 32'h0000_0000)
		else $error("port pin not carrying port data");
	cover property (bvalid && bresp == `LCD_RESP_SLVERR);
	cover property (commonUsed == 4'hF);
	cover property (standbyMode && com == 4'h0);
endmodule
bind lcd_segment_driver_ctrl lcd_seg_ctrl_sva chk_u (.clk_sys(clk_sys), .rstn(rstn),
	.awready(awready), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arready(arready), .rvalid(rvalid), .rready(rready), .standbyMode(standbyMode),
	.portData(portData), .segmentOutputs(segmentOutputs), .segmentIsPort(segmentIsPort),
	.commonOut1(commonOut1), .commonOut2(commonOut2), .commonOut3(commonOut3),
	.commonOut4(commonOut4), .commonUsed(commonUsed), .drivePowerOn(drivePowerOn));

// >>> test/test_lcd_segment_driver_ctrl.sv
// self-checking bench for the segment display controller
`timescale 1ns/1ns
`include "lcd_seg_defines.svh"
module test_lcd_segment_driver_ctrl;
	logic             clk_sys = 1'b0, rstn = 1'b0, standbyMode = 1'b0, clearCounts = 1'b0;
	logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [17:0]      awaddr = 18'h0_0000, araddr = 18'h0_0000;
	logic [31:0]      wdata = 32'h0000_0000, portData = 32'hA5C3_0F96;
	logic [3:0]       wstrb = 4'h0;
	logic             awready, wready, bvalid, arready, rvalid, drivePowerOn, ladderConnected;
	logic             commonOut1, commonOut2, commonOut3, commonOut4;
	logic [1:0]       bresp, rresp, readResp;
	logic [31:0]      rdata, segmentOutputs, segmentIsPort, readData;
	logic [3:0]       commonUsed, expU;
	logic [3:0][7:0]  changeCount;
	int               fail_count = 0, cmp_count = 0, waitCount = 0;

	always #10 clk_sys = ~clk_sys;

	lcd_segment_driver_ctrl dut_u (.clk_sys(clk_sys), .rstn(rstn), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .standbyMode(standbyMode),
		.portData(portData), .segmentOutputs(segmentOutputs), .segmentIsPort(segmentIsPort),
		.commonOut1(commonOut1), .commonOut2(commonOut2), .commonOut3(commonOut3),
		.commonOut4(commonOut4), .commonUsed(commonUsed), .drivePowerOn(drivePowerOn),
		.ladderConnected(ladderConnected));
	lcd_panel_model panel_u (.clk_sys(clk_sys), .rstn(rstn), .clearCounts(clearCounts),
		.commons({commonOut4, commonOut3, commonOut2, commonOut1}), .changeCount(changeCount));

	// ----
	// bus and compare tasks
	// ----
	task automatic end_sim();
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cmpv(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmpr(input logic [1:0] got, input logic [1:0] exp);
		cmpv({30'h0, got}, {30'h0, exp});
	endtask
	// every wait after the reset edges runs through here, so a hang cannot outlast the bound
	task automatic step();
		@(posedge clk_sys);
		waitCount++;
		if (waitCount > 4000) begin
			fail_count++;
			end_sim();
		end
	endtask
	task automatic idle(input int n);
		waitCount = 0;
		repeat (n) step();
	endtask
	task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] s);
		waitCount = 0;
		awaddr <= {idx, 2'b00};
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (bvalid !== 1'b1) begin
			step();
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end
		readResp = bresp;
		bready <= 1'b0;
		// one edge between transfers, so a valid is never lowered and raised in one step
		step();
	endtask
	task automatic rd(input logic [15:0] idx);
		waitCount = 0;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (rvalid !== 1'b1) begin
			step();
			if (arready === 1'b1) arvalid <= 1'b0;
		end
		readData = rdata;
		readResp = rresp;
		rready <= 1'b0;
		step();
	endtask
	task automatic wrc(input logic [15:0] idx, input logic [31:0] d);
		wr(idx, d, 4'h1);
		cmpr(readResp, `LCD_RESP_OKAY);
	endtask
	task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
		rd(idx);
		cmpv(readData, exp);
		cmpr(readResp, `LCD_RESP_OKAY);
	endtask
	task automatic clr();
		clearCounts <= 1'b1;
		idle(1);
		clearCounts <= 1'b0;
		idle(1);
	endtask
	task automatic waitCom(output int n);
		logic c;
		waitCount = 0;
		c = commonOut1;
		n = 0;
		do begin
			step();
			n++;
		end while (commonOut1 === c);
	endtask
	function automatic logic [31:0] portMask(input logic [3:0] sel);
		logic [31:0] m;
		for (int g = 0; g < 8; g++)
			m[4*g +: 4] = (sel[3] ? (g >= sel[2:0]) : (g < sel[2:0])) ? 4'h0 : 4'hF;
		return m;
	endfunction

	// ----
	// main sequence
	// ----
	initial begin
		int bad, diff, gap;
		logic [3:0] com;
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		rchk(`LCD_IDX_PIN_DUTY, 32'h0000_0000);
		rchk(`LCD_IDX_DISP_CTRL, 32'h0000_0080);
		rchk(`LCD_IDX_CLK_GATE2, 32'h0000_00FF);
		rd(16'h0100);
		cmpr(readResp, `LCD_RESP_SLVERR);
		wr(16'h0100, 32'h0000_00FF, 4'h1);
		cmpr(readResp, `LCD_RESP_SLVERR);
		wrc(`LCD_IDX_PIN_DUTY, 32'h0000_00EF);
		rchk(`LCD_IDX_PIN_DUTY, 32'h0000_00EF);
		wrc(`LCD_IDX_DISP_CTRL, 32'h0000_0000);
		rchk(`LCD_IDX_DISP_CTRL, 32'h0000_0080);
		wr(`LCD_IDX_RAM_BASE, 32'h0000_1234, 4'h3);
		rchk(`LCD_IDX_RAM_BASE, 32'h0000_1234);
		rchk(`LCD_IDX_RAM_BASE + 16'h0001, 32'h0000_0012);
		for (int s = 0; s < 16; s++) begin
			portData <= ~portData;
			wrc(`LCD_IDX_PIN_DUTY, {28'h0, s[3:0]});
			idle(3);
			cmpv(segmentIsPort, portMask(s[3:0]));
			cmpv(segmentOutputs & portMask(s[3:0]), portData & portMask(s[3:0]));
		end
		wrc(`LCD_IDX_DISP_CTRL, 32'h0000_0070);
		wrc(`LCD_IDX_DISP_CTRL2, 32'h0000_0040);
		idle(3);
		cmpv(ladderConnected, 1'b0);
		cmpv(drivePowerOn, 1'b1);
		// type B keeps every used common moving in all duties
		wrc(`LCD_IDX_DISP_CTRL2, 32'h0000_0080);
		idle(3);
		cmpv(ladderConnected, 1'b1);
		for (int m = 0; m < 8; m++) begin
			wrc(`LCD_IDX_PIN_DUTY, {24'h0, m[2:1], m[0], 5'h00});
			expU = (m == 1 || m == 3 || m >= 6) ? 4'hF : (m == 0) ? 4'h1 : (m == 2) ? 4'h3 : 4'h7;
			idle(4);
			clr();
			bad = 0;
			diff = 0;
			repeat (1300) begin
				step();
				com = {commonOut4, commonOut3, commonOut2, commonOut1};
				if (m == 1 && com != {4{com[0]}}) bad++;
				if (m == 3 && (com[3] != com[2] || com[1] != com[0])) bad++;
				if (com[1] != com[0]) diff++;
			end
			cmpv(commonUsed, expU);
			cmpv(bad, 0);
			for (int c = 0; c < 4; c++)
				cmpv(changeCount[c] != 8'h00, expU[c]);
			if (m >= 6) cmpv(diff != 0, 1'b1);
		end
		wrc(`LCD_IDX_PIN_DUTY, 32'h0000_0040);
		wrc(`LCD_IDX_DISP_CTRL2, 32'h0000_0000);
		idle(4);
		clr();
		idle(1300);
		cmpv(changeCount[0] <= 8'h01, 1'b1);
		// even segments lit, odd ones dark, in every byte
		for (int i = 0; i < 16; i += 2)
			wr(`LCD_IDX_RAM_BASE + 16'(i), 32'h0000_0101, 4'h3);
		wrc(`LCD_IDX_PIN_DUTY, 32'h0000_0008);
		for (int f = 0; f < 3; f++) begin
			wrc(`LCD_IDX_DISP_CTRL, 32'h0000_0070 | f);
			waitCom(gap);
			waitCom(gap);
			waitCom(gap);
			cmpv(gap, 256 << f);
			cmpv(segmentOutputs, {32{commonOut1}} ^ 32'h5555_5555);
		end
		// display off: every segment follows its common, nothing lit
		wrc(`LCD_IDX_DISP_CTRL, 32'h0000_0060);
		idle(3);
		cmpv(segmentOutputs, {32{commonOut1}});
		wrc(`LCD_IDX_DISP_CTRL, 32'h0000_0070);
		for (int k = 0; k < 2; k++) begin
			if (k == 0) standbyMode <= 1'b1;
			else wrc(`LCD_IDX_CLK_GATE2, 32'h0000_00FE);
			idle(8);
			clr();
			idle(600);
			cmpv(changeCount, 32'h0000_0000);
			cmpv({commonOut4, commonOut3, commonOut2, commonOut1}, 4'h0);
			cmpv(segmentOutputs, 32'h0000_0000);
			cmpv(drivePowerOn, 1'b0);
			standbyMode <= 1'b0;
			wrc(`LCD_IDX_CLK_GATE2, 32'h0000_00FF);
			clr();
			idle(600);
			cmpv(changeCount[0] != 8'h00, 1'b1);
		end
		end_sim();
	end
endmodule
